// ### pkg/qadc_pkg.sv
`default_nettype none
package qadc_pkg;
  localparam int NCH = 4;
  localparam int WORD_W = 12;
  localparam int BITS_PER_FRAME = 12;
  localparam int SER_MULT = 12;
  localparam int BCLK_MULT = 6;
  localparam int IDX_W = 4;
  localparam int PER_W = 8;
  localparam logic [IDX_W-1:0] IDX_HALF = IDX_W'(BITS_PER_FRAME / 2);
  localparam logic [IDX_W-1:0] IDX_LAST = IDX_W'(BITS_PER_FRAME - 1);

  // register port
  localparam int ADDR_W = 4;
  localparam int DATA_W = 16;
  localparam logic [ADDR_W-1:0] OFS_CTRL = 4'h0;
  localparam logic [ADDR_W-1:0] OFS_CHAN_PD = 4'h1;
  localparam logic [ADDR_W-1:0] OFS_CUSTOM = 4'h2;
  localparam logic [ADDR_W-1:0] OFS_STATUS = 4'h3;
  localparam int CTRL_MSB_FIRST = 0;
  localparam int CTRL_DESKEW = 1;
  localparam int CTRL_SYNC = 2;
  localparam int CTRL_CUSTOM = 3;
  localparam int CTRL_MON_DIS = 4;
  localparam int CTRL_EXT_REF = 5;
  localparam int CTRL_DRV_LSB = 6;
  localparam int STAT_LOCKED = 0;
  localparam int STAT_STOPPED = 1;
  localparam int STAT_PDN = 2;
  localparam int STAT_RATE_OK = 3;
  localparam logic [DATA_W-1:0] CTRL_RST = 16'h0000;

  // latency: whole sample periods before the half-period hand-over
  localparam int LAT_WHOLE = 6;
  localparam int PIPE_STAGES = LAT_WHOLE + 1;

  // timing
  localparam int CLK_PERIOD_PS = 5000;
  localparam int MON_MIN_FREQ_KHZ = 3000;
  localparam int MON_LIMIT_CYC = (1000000000 / MON_MIN_FREQ_KHZ) / CLK_PERIOD_PS;
  localparam int PLL_MIN_RATE_KHZ = 20000;
  localparam int PLL_MAX_PERIOD_CYC = (1000000000 / PLL_MIN_RATE_KHZ) / CLK_PERIOD_PS;

  typedef enum logic [1:0] {
    QADC_DRV_3MA5 = 2'h0,
    QADC_DRV_LOW = 2'h1,
    QADC_DRV_HIGH = 2'h2,
    QADC_DRV_DOUBLE = 2'h3
  } qadc_drive_t;

  typedef struct packed {
    logic msb_first;
    logic deskew;
    logic sync;
    logic custom;
    logic mon_dis;
    logic ext_ref;
    qadc_drive_t drv;
    logic [NCH-1:0] chan_pd;
    logic [WORD_W-1:0] custom_pat;
  } qadc_ctrl_t;

  function automatic logic [IDX_W-1:0] qadc_bit_sel(input logic [IDX_W-1:0] idx,
                                                    input logic msb_first);
    return msb_first ? (IDX_W'(WORD_W - 1) - idx) : idx;
  endfunction : qadc_bit_sel
endpackage : qadc_pkg
`default_nettype wire

// ### design/qadc_lane_bit.sv
`timescale 1ns/1ps
`default_nettype none
module qadc_lane_bit (
  input wire logic [qadc_pkg::WORD_W-1:0] word,
  input wire logic [qadc_pkg::IDX_W-1:0] idx,
  input wire logic msb_first,
  input wire logic deskew,
  input wire logic sync,
  input wire logic custom_en,
  input wire logic [qadc_pkg::WORD_W-1:0] custom_pat,
  output logic bit_out
);
  import qadc_pkg::*;

  always_comb begin
    if (deskew) begin
      bit_out = idx[0];
    end else if (sync) begin
      bit_out = (idx >= IDX_HALF);
    end else if (custom_en) begin
      bit_out = custom_pat[qadc_bit_sel(idx, msb_first)];
    end else begin
      bit_out = word[qadc_bit_sel(idx, msb_first)];
    end
  end
endmodule : qadc_lane_bit
`default_nettype wire

// ### design/qadc_clk_mon.sv
`timescale 1ns/1ps
`default_nettype none
module qadc_clk_mon #(
  parameter int LIMIT = qadc_pkg::MON_LIMIT_CYC
) (
  input wire logic mclk,
  input wire logic resetn,
  input wire logic ce,
  input wire logic clk_edge,
  output logic stopped
);
  import qadc_pkg::*;

  typedef struct packed {
    logic [PER_W-1:0] cnt;
    logic stopped;
  } qadc_mon_state_t;

  qadc_mon_state_t r;
  qadc_mon_state_t nx;

  always_comb begin
    nx = r;
    if (ce) begin
      if (clk_edge) begin
        nx.cnt = '0;
      end else if (r.cnt != PER_W'(LIMIT)) begin
        nx.cnt = r.cnt + PER_W'(1);
      end
      // no edge for a slow period
      nx.stopped = !clk_edge && (nx.cnt >= PER_W'(LIMIT));
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      r <= '0;
    end else begin
      r <= nx;
    end
  end

  assign stopped = r.stopped;

  default clocking cb_mon @(posedge mclk);
  endclocking
  default disable iff (!resetn);

  property p_mon_release;
    clk_edge && ce |=> !stopped;
  endproperty
  a_mon_release: assert property (p_mon_release) else $error("monitor stayed stopped");
endmodule : qadc_clk_mon
`default_nettype wire

// ### design/qadc_top.sv
`timescale 1ns/1ps
`default_nettype none
module qadc_top (
  input wire logic mclk,
  input wire logic resetn,
  input wire logic ce,
  input wire logic sample_clock_in,
  input wire logic power_down_request,
  input wire logic [qadc_pkg::NCH-1:0][qadc_pkg::WORD_W-1:0] conv_data,
  input wire logic [qadc_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [qadc_pkg::DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [qadc_pkg::DATA_W-1:0] reg_rdata,
  output logic [qadc_pkg::NCH-1:0] serial_data_lane,
  output logic bit_clock_out,
  output logic frame_clock_out,
  output logic [qadc_pkg::NCH-1:0] chan_sample_pulse,
  output logic ref_power_down,
  output logic clock_power_down,
  output logic [qadc_pkg::NCH-1:0] chan_power_down,
  output logic ref_driver_hiz,
  output logic [1:0] drive_current_sel
);
  import qadc_pkg::*;

  typedef struct packed {
    logic s1;
    logic s2;
    logic s_prev;
    logic p1;
    logic p2;
    qadc_ctrl_t ctrl;
    logic [PER_W-1:0] per_cnt;
    logic [PER_W-1:0] period;
    logic [PER_W:0] acc;
    logic [IDX_W-1:0] idx;
    logic [IDX_W-1:0] out_idx;
    logic seen;
    logic running;
    logic act;
    logic [PIPE_STAGES-1:0][NCH-1:0][WORD_W-1:0] pipe;
    logic [NCH-1:0][WORD_W-1:0] hold;
    logic [NCH-1:0][WORD_W-1:0] frame;
    logic [NCH-1:0] lane;
    logic [NCH-1:0] ch_pd;
    logic [NCH-1:0] ch_smp;
    logic bclk;
    logic fclk;
    logic ref_pd;
    logic clk_pd;
    logic ref_hiz;
    logic [1:0] drv;
    logic [DATA_W-1:0] rdata;
  } qadc_top_state_t;

  qadc_top_state_t r;
  qadc_top_state_t nx;
  logic rise;
  logic fall;
  logic pdn;
  logic mon_stopped;
  logic [NCH-1:0] lane_bits;

  // edges seen only on the second synchroniser stage
  assign rise = r.s2 && !r.s_prev;
  assign fall = !r.s2 && r.s_prev;
  assign pdn = r.p2 || (mon_stopped && !r.ctrl.mon_dis);

  qadc_clk_mon #(
    .LIMIT(MON_LIMIT_CYC)
  ) u_mon (
    .mclk(mclk),
    .resetn(resetn),
    .ce(ce),
    .clk_edge(rise),
    .stopped(mon_stopped)
  );

  // one shared index and control for all lanes
  for (genvar c = 0; c < NCH; c++) begin : g_lane
    qadc_lane_bit u_lane (
      .word(r.frame[c]),
      .idx(r.idx),
      .msb_first(r.ctrl.msb_first),
      .deskew(r.ctrl.deskew),
      .sync(r.ctrl.sync),
      .custom_en(r.ctrl.custom),
      .custom_pat(r.ctrl.custom_pat),
      .bit_out(lane_bits[c])
    );
  end

  always_comb begin
    logic [PER_W:0] acc_sum;
    logic [DATA_W-1:0] rd;
    acc_sum = '0;
    rd = '0;
    nx = r;
    if (ce) begin
      nx.s1 = sample_clock_in;
      nx.s2 = r.s1;
      nx.s_prev = r.s2;
      nx.p1 = power_down_request;
      nx.p2 = r.p1;

      if (reg_wr) begin
        case (reg_addr)
          OFS_CTRL: begin
            nx.ctrl.msb_first = reg_wdata[CTRL_MSB_FIRST];
            nx.ctrl.deskew = reg_wdata[CTRL_DESKEW];
            nx.ctrl.sync = reg_wdata[CTRL_SYNC];
            nx.ctrl.custom = reg_wdata[CTRL_CUSTOM];
            nx.ctrl.mon_dis = reg_wdata[CTRL_MON_DIS];
            nx.ctrl.ext_ref = reg_wdata[CTRL_EXT_REF];
            nx.ctrl.drv = qadc_drive_t'(reg_wdata[CTRL_DRV_LSB +: 2]);
          end
          OFS_CHAN_PD: nx.ctrl.chan_pd = reg_wdata[NCH-1:0];
          OFS_CUSTOM: nx.ctrl.custom_pat = reg_wdata[WORD_W-1:0];
          default: ;
        endcase
      end

      case (reg_addr)
        OFS_CTRL: begin
          rd[CTRL_MSB_FIRST] = r.ctrl.msb_first;
          rd[CTRL_DESKEW] = r.ctrl.deskew;
          rd[CTRL_SYNC] = r.ctrl.sync;
          rd[CTRL_CUSTOM] = r.ctrl.custom;
          rd[CTRL_MON_DIS] = r.ctrl.mon_dis;
          rd[CTRL_EXT_REF] = r.ctrl.ext_ref;
          rd[CTRL_DRV_LSB +: 2] = r.ctrl.drv;
        end
        OFS_CHAN_PD: rd[NCH-1:0] = r.ctrl.chan_pd;
        OFS_CUSTOM: rd[WORD_W-1:0] = r.ctrl.custom_pat;
        OFS_STATUS: begin
          rd[STAT_LOCKED] = r.running;
          rd[STAT_STOPPED] = mon_stopped;
          rd[STAT_PDN] = r.clk_pd;
          // only reported: below this rate the multiplier would not lock
          rd[STAT_RATE_OK] = r.seen && (r.period <= PER_W'(PLL_MAX_PERIOD_CYC));
        end
        default: rd = '0;
      endcase
      nx.rdata = reg_rd ? rd : '0;

      if (rise) begin
        // measured period drives the 12x bit timing
        nx.period = r.per_cnt;
        nx.per_cnt = PER_W'(1);
        nx.seen = 1'b1;
        nx.running = r.seen;
        // every frame restarts on the sample edge
        nx.idx = '0;
        nx.acc = '0;
        nx.frame = r.hold;
        // whole periods of latency; codes pass unchanged
        nx.pipe[0] = conv_data;
        for (int i = 1; i < PIPE_STAGES; i++) begin
          nx.pipe[i] = r.pipe[i-1];
        end
      end else begin
        if (r.per_cnt != '1) begin
          nx.per_cnt = r.per_cnt + PER_W'(1);
        end
        // twelve bit slots per measured period
        if (r.running && (r.idx != IDX_LAST)) begin
          acc_sum = r.acc + (PER_W+1)'(SER_MULT);
          if (acc_sum >= {1'b0, r.period}) begin
            nx.acc = acc_sum - {1'b0, r.period};
            nx.idx = r.idx + IDX_W'(1);
          end else begin
            nx.acc = acc_sum;
          end
        end
      end
      // the last half period ends on the falling edge
      if (fall) begin
        nx.hold = r.pipe[PIPE_STAGES-1];
      end
      if (pdn) begin
        nx.running = 1'b0;
        nx.seen = 1'b0;
      end

      // lanes registered one cycle after the index
      nx.act = r.running;
      nx.out_idx = r.idx;
      nx.lane = r.running ? lane_bits : '0;
      // one bit clock period per two bits, both edges used
      nx.bclk = r.running && !r.idx[0];
      // high for six slots, low for six, any input duty
      nx.fclk = r.running && (r.idx < IDX_HALF);
      // one flop edge samples every powered-up channel
      nx.ch_smp = (rise && !pdn) ? ~r.ctrl.chan_pd : '0;
      nx.ref_pd = pdn;
      nx.clk_pd = pdn;
      nx.ch_pd = {NCH{pdn}} | r.ctrl.chan_pd;
      nx.ref_hiz = r.ctrl.ext_ref;
      nx.drv = r.ctrl.drv;
    end
  end

  // reset clears all configuration to zero
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      r <= '0;
    end else begin
      r <= nx;
    end
  end

  assign reg_rdata = r.rdata;
  assign serial_data_lane = r.lane;
  assign bit_clock_out = r.bclk;
  assign frame_clock_out = r.fclk;
  assign chan_sample_pulse = r.ch_smp;
  assign ref_power_down = r.ref_pd;
  assign clock_power_down = r.clk_pd;
  assign chan_power_down = r.ch_pd;
  assign ref_driver_hiz = r.ref_hiz;
  assign drive_current_sel = r.drv;

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!resetn);

  property p_deskew;
    (r.act && r.ctrl.deskew && $stable(r.ctrl)) |->
      (serial_data_lane == {NCH{r.out_idx[0]}}) && (bit_clock_out != r.out_idx[0]);
  endproperty
  a_deskew: assert property (p_deskew) else $error("deskew pattern wrong");

  property p_sync;
    (r.act && r.ctrl.sync && !r.ctrl.deskew && $stable(r.ctrl)) |->
      serial_data_lane == {NCH{!frame_clock_out}};
  endproperty
  a_sync: assert property (p_sync) else $error("sync pattern wrong");

  property p_custom_order;
    (r.act && r.ctrl.custom && !r.ctrl.sync && !r.ctrl.deskew && $stable(r.ctrl)) |->
      serial_data_lane == {NCH{r.ctrl.custom_pat[qadc_bit_sel(r.out_idx, r.ctrl.msb_first)]}};
  endproperty
  a_custom_order: assert property (p_custom_order) else $error("custom bit wrong");

  property p_frame_start;
    (rise && r.running && !pdn && ce) ##1 (ce && r.running) |=>
      frame_clock_out && bit_clock_out && (r.out_idx == '0);
  endproperty
  a_frame_start: assert property (p_frame_start) else $error("frame start not aligned");

  property p_pin_pd;
    (r.p2 && ce) |=> ref_power_down && clock_power_down && (&chan_power_down);
  endproperty
  a_pin_pd: assert property (p_pin_pd) else $error("pin power-down missed");

  property p_chan_pd;
    ce |=> ((chan_power_down & $past(r.ctrl.chan_pd)) == $past(r.ctrl.chan_pd));
  endproperty
  a_chan_pd: assert property (p_chan_pd) else $error("channel power-down missed");

  property p_mon_force;
    (mon_stopped && !r.ctrl.mon_dis && ce) |=> clock_power_down && ref_power_down;
  endproperty
  a_mon_force: assert property (p_mon_force) else $error("stopped clock not powered down");

  property p_mon_disable;
    (r.ctrl.mon_dis && !r.p2 && ce) |=> !clock_power_down;
  endproperty
  a_mon_disable: assert property (p_mon_disable) else $error("monitor disable ignored");

  property p_reset_zero;
    $rose(resetn) |-> (r.ctrl == '0) && (drive_current_sel == QADC_DRV_3MA5);
  endproperty
  a_reset_zero: assert property (p_reset_zero) else $error("config not zero after reset");

  property p_ref_hiz;
    ce |=> (ref_driver_hiz == $past(r.ctrl.ext_ref));
  endproperty
  a_ref_hiz: assert property (p_ref_hiz) else $error("reference driver state wrong");

  property p_matched;
    (chan_sample_pulse != '0) |-> (chan_sample_pulse == ~chan_power_down);
  endproperty
  a_matched: assert property (p_matched) else $error("channels sampled apart");

  c_deskew: cover property (r.act && r.ctrl.deskew);
  c_sync: cover property (r.act && r.ctrl.sync && !r.ctrl.deskew);
  c_msb_data: cover property ($rose(frame_clock_out) && r.ctrl.msb_first);
  c_stop_pd: cover property ($rose(mon_stopped) ##1 clock_power_down);
endmodule : qadc_top
`default_nettype wire

// ### tb/qadc_rx_model.sv
`timescale 1ns/1ps
`default_nettype none
module qadc_rx_model (
  input wire logic mclk,
  input wire logic resetn,
  input wire logic [qadc_pkg::NCH-1:0] lane,
  input wire logic bclk,
  input wire logic fclk,
  output logic [qadc_pkg::NCH-1:0][qadc_pkg::WORD_W-1:0] rx_word,
  output logic [4:0] rx_slots,
  output logic [4:0] rx_fhigh,
  output logic rx_valid
);
  import qadc_pkg::*;
  logic bclk_d = 1'b0;
  logic fclk_d = 1'b0;
  logic [4:0] slot = 5'h00;
  logic [4:0] fh = 5'h00;
  logic [NCH-1:0][WORD_W-1:0] acc = '0;

  always @(posedge mclk) begin
    rx_valid <= 1'b0;
    // take a bit on either bit clock edge
    if (bclk !== bclk_d) begin
      // frame clock rise opens a new word
      if (fclk && !fclk_d) begin
        rx_word <= acc;
        rx_slots <= slot;
        rx_fhigh <= fh;
        rx_valid <= resetn;
        slot = 5'h00;
        fh = 5'h00;
      end
      // slots past the word width are counted, not stored
      for (int c = 0; c < NCH; c++) if (slot < 5'(WORD_W)) acc[c][slot[3:0]] = lane[c];
      fh = fh + 5'(fclk);
      slot = slot + 5'h01;
    end
    bclk_d = bclk;
    fclk_d = fclk;
  end
endmodule : qadc_rx_model
`default_nettype wire

// ### tb/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import qadc_pkg::*;
  logic mclk = 1'b0;
  logic resetn, sclk, run_sclk, pd_pin, reg_wr, reg_rd, msb, pulse_chk, hiz, bclk, fclk, rx_valid;
  logic ref_pd, clk_pd;
  logic [ADDR_W-1:0] reg_addr;
  logic [DATA_W-1:0] reg_wdata, reg_rdata, v;
  logic [NCH-1:0][WORD_W-1:0] conv_data, rx_word;
  logic [NCH-1:0][WORD_W-1:0] hist [0:4095];
  logic [NCH-1:0] lanes, pulse, ch_pd;
  logic [1:0] drv;
  logic [4:0] rx_slots, rx_fhigh;
  logic [11:0] cust;
  int bad_count = 0;
  int checks = 0;
  int rises = 0;
  int cstamp = 0;
  int pstamp = 0;
  int chk_from = 9999;
  int mode = 0;
  int md [5] = '{1, 2, 3, 1, 2};
  logic [3:0] pat [5] = '{4'h2, 4'h4, 4'h8, 4'he, 4'hc};

  qadc_top qadc_top_i (.mclk(mclk), .resetn(resetn), .ce(1'b1), .sample_clock_in(sclk),
    .power_down_request(pd_pin), .conv_data(conv_data), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .serial_data_lane(lanes), .bit_clock_out(bclk), .frame_clock_out(fclk),
    .chan_sample_pulse(pulse), .ref_power_down(ref_pd), .clock_power_down(clk_pd),
    .chan_power_down(ch_pd), .ref_driver_hiz(hiz), .drive_current_sel(drv));
  qadc_rx_model qadc_rx_model_i (.mclk(mclk), .resetn(resetn), .lane(lanes), .bclk(bclk),
    .fclk(fclk), .rx_word(rx_word), .rx_slots(rx_slots), .rx_fhigh(rx_fhigh),
    .rx_valid(rx_valid));

  initial begin
    forever #2.5 mclk = ~mclk;
  end
  // offset keeps pin edges away from mclk edges
  initial begin
    sclk = 1'b0;
    #3.1;
    forever #62.5 sclk = run_sclk ? ~sclk : 1'b0;
  end

  task automatic cmp(input string what, input logic [15:0] exp, input logic [15:0] got);
    checks++;
    if (got !== exp) begin
      bad_count++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask : cmp
  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
  endtask : cyc
  task automatic frames(input int n);
    repeat (n) @(posedge fclk);
  endtask : frames
  task automatic arm(input int n);
    chk_from = rises + n;
  endtask : arm
  task automatic done(input string name);
    $display("test %s finished, %0d checks so far", name, checks);
  endtask : done
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge mclk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
    @(posedge mclk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    @(posedge mclk);
    d = reg_rdata;
  endtask : rd
  task automatic check_defaults();
    wr(4'h9, 16'hffff);
    foreach (pat[i]) begin
      rd(ADDR_W'(i == 3 ? 9 : i), v);
      if (i < 4) cmp("reset or unmapped read", 16'h0000, v);
    end
    cmp("drive select", 16'h0000, 16'(drv));
    cmp("reference hiz", 16'h0000, 16'(hiz));
  endtask : check_defaults
  task automatic stop_test();
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : stop_test

  // word in slot order: bit n is the bit seen in slot n
  function automatic logic [11:0] exp_word(input logic [11:0] d);
    logic [11:0] w;
    w = (mode == 3) ? cust : d;
    if (msb) w = {<<{w}};
    if (mode == 2) w = 12'hfc0;
    if (mode == 1) w = 12'haaa;
    return w;
  endfunction : exp_word

  always @(negedge sclk) begin
    @(posedge mclk);
    for (int c = 0; c < NCH; c++) conv_data[c] <= ($urandom_range(3) == 0) ? {12{$urandom_range(1) == 1}} : 12'($urandom);
  end
  always @(posedge sclk) begin
    hist[rises] = conv_data;
    rises++;
  end
  always @(posedge fclk) begin
    pstamp = cstamp;
    cstamp = rises;
  end
  always @(posedge mclk) begin
    if (pulse_chk && pulse != '0) cmp("sample pulse", {12'h0, ~ch_pd}, {12'h0, pulse});
    if (rx_valid && pstamp >= chk_from) begin
      for (int c = 0; c < NCH; c++) if (!ch_pd[c]) cmp("lane word", 16'(exp_word(hist[pstamp - 8][c])), 16'(rx_word[c]));
      cmp("bit slots per frame", 16'd12, 16'(rx_slots));
      cmp("frame high slots", 16'd6, 16'(rx_fhigh));
    end
  end

  initial begin
    #100000;
    bad_count++;
    stop_test();
  end

  initial begin
    {resetn, run_sclk, pd_pin, reg_wr, reg_rd, msb, pulse_chk} = '0;
    reg_addr = '0;
    reg_wdata = '0;
    conv_data = '0;
    cust = '0;
    void'($urandom(32'hb1d95a65));
    cyc(5);
    resetn <= 1'b1;
    check_defaults();
    done("defaults");
    run_sclk = 1'b1;
    pulse_chk = 1'b1;
    arm(12);
    frames(20);
    rd(OFS_STATUS, v);
    cmp("status running", 16'h0001, v);
    done("data lsb first");
    arm(9999);
    msb = 1'b1;
    wr(OFS_CTRL, 16'h0001);
    arm(3);
    frames(10);
    done("data msb first");
    foreach (md[i]) begin
      arm(9999);
      cust = 12'($urandom);
      wr(OFS_CUSTOM, {4'h0, cust});
      mode = md[i];
      msb = 1'($urandom);
      wr(OFS_CTRL, {12'h000, pat[i][3:1], msb});
      arm(3);
      frames(5);
    end
    done("patterns");
    arm(9999);
    mode = 0;
    msb = 1'b0;
    for (int d = 0; d < 4; d++) begin
      wr(OFS_CTRL, 16'(d << 6) | 16'((d & 1) << 5));
      cyc(2);
      cmp("drive select", 16'(d), 16'(drv));
      cmp("reference hiz", 16'(d & 1), 16'(hiz));
      rd(OFS_CTRL, v);
      cmp("control readback", 16'(d << 6) | 16'((d & 1) << 5), v);
    end
    arm(3);
    pulse_chk = 1'b0;
    wr(OFS_CHAN_PD, 16'h0005);
    cyc(3);
    pulse_chk = 1'b1;
    cmp("channel power down", 16'h0005, 16'(ch_pd));
    frames(4);
    pulse_chk = 1'b0;
    wr(OFS_CHAN_PD, 16'h0000);
    done("channel power down");
    arm(9999);
    pd_pin <= 1'b1;
    cyc(4);
    pulse_chk = 1'b1;
    cmp("global power down", 16'h003f, 16'({ref_pd, clk_pd, ch_pd}));
    cyc(60);
    cmp("lanes idle", 16'h0000, 16'(lanes));
    pulse_chk = 1'b0;
    pd_pin <= 1'b0;
    frames(3);
    arm(12);
    frames(15);
    done("power down pin");
    arm(9999);
    run_sclk = 1'b0;
    cyc(100);
    cmp("monitor power down", 16'h0001, 16'(clk_pd));
    rd(OFS_STATUS, v);
    cmp("status stopped", 16'h0001, 16'(v[STAT_STOPPED]));
    cmp("status word", 16'h0006, v);
    run_sclk = 1'b1;
    frames(3);
    wr(OFS_CTRL, 16'h0010);
    run_sclk = 1'b0;
    cyc(100);
    cmp("monitor disabled", 16'h0000, 16'(clk_pd));
    run_sclk = 1'b1;
    arm(12);
    frames(15);
    done("clock monitor");
    arm(9999);
    wr(OFS_CTRL, 16'h00ff);
    @(posedge mclk);
    resetn <= 1'b0;
    cyc(3);
    resetn <= 1'b1;
    check_defaults();
    arm(12);
    frames(15);
    done("mid-run reset");
    stop_test();
  end
endmodule : tb_top
`default_nettype wire
